// ===== core/cim_pkg.sv
// Shared constants and types of the four-channel current input block
`default_nettype none
package cim_pkg;
  // Channel and word geometry
  localparam int CH_CNT = 4;
  localparam int CH_W = 2;
  localparam int SAMPLE_W = 12;
  localparam int WORD_W = 16;
  localparam int RAW_W = 14;
  // Field positions inside the host input word
  localparam int SAMPLE_LSB = 0;
  localparam int SAMPLE_MSB = 11;
  localparam int CODE_LOW_BIT = 12;
  localparam int CODE_HIGH_BIT = 13;
  localparam int BUSY_BIT = 14;
  localparam int SUPPLY_BIT = 15;
  // Sample scaling: top of range and missing-supply marker
  localparam logic [SAMPLE_W-1:0] SAMPLE_MAX = 12'hFFF;
  localparam logic [SAMPLE_W-1:0] SAMPLE_ZERO = 12'h000;
  localparam logic [WORD_W-1:0] PTR_SUPPLY_WORD = 16'h8000;
  localparam logic [CH_W-1:0] CH_FIRST = 2'h0;
  // Raw converter code at the low end of the range, and gain in Q16
  localparam logic [RAW_W-1:0] RAW_LO = 14'h0CCC;
  localparam int GAIN_W = 16;
  localparam int GAIN_SHIFT = 16;
  localparam logic [GAIN_W-1:0] GAIN = 16'h4FFC;
  // Conversion pacing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_INTERVAL_NS = 10000;
  localparam int CONV_CYCLES =
    (CONV_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Host-facing sequencer states
  typedef enum logic [2:0]
  {
    CIM_ST_IDLE = 3'b001,
    CIM_ST_MUX = 3'b010,
    CIM_ST_PTR = 3'b100
  } cim_state_e;
endpackage : cim_pkg
`default_nettype wire

// ===== core/cim_conv_if.sv
// Carrier between the sequencer and the sample scaler
`default_nettype none
interface cim_conv_if;
  import cim_pkg::*;
  logic [RAW_W-1:0] raw;
  logic raw_valid;
  logic [CH_W-1:0] raw_chan;
  logic [SAMPLE_W-1:0] sample;
  logic sample_valid;
  logic [CH_W-1:0] sample_chan;
  modport seq (output raw, raw_valid, raw_chan,
               input sample, sample_valid, sample_chan);
  modport scaler (input raw, raw_valid, raw_chan,
                  output sample, sample_valid, sample_chan);
endinterface : cim_conv_if
`default_nettype wire

// ===== core/cim_sample_mem.sv
// Per-channel sample store with registered read data
`default_nettype none
module cim_sample_mem
  import cim_pkg::*;
#(
  parameter int WIDTH = SAMPLE_W,
  parameter int DEPTH = CH_CNT
)
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic rd_en_in,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);
  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rd_data;
  } cim_mem_s;

  cim_mem_s r;
  cim_mem_s n;

  if (DEPTH < 2 || WIDTH < 1)
  begin : g_bad
    $error("cim_sample_mem: unsupported geometry");
  end

  ////////////////////////////////////////////////////////////////////////
  // Write and read ports
  always_comb
  begin
    n = r;
    if (wr_en_in)
    begin
      n.mem[wr_addr_in] = wr_data_in;
    end
    if (rd_en_in)
    begin
      n.rd_data = r.mem[rd_addr_in];
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign rd_data_out = r.rd_data;
endmodule : cim_sample_mem
`default_nettype wire

// ===== core/cim_scaler.sv
// Linear scaling of raw converter codes onto the 0..FFF sample range
`default_nettype none
module cim_scaler
  import cim_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  cim_conv_if.scaler conv
);
  localparam int PROD_W = RAW_W + GAIN_W;

  typedef struct packed
  {
    logic valid;
    logic [CH_W-1:0] chan;
    logic [SAMPLE_W-1:0] sample;
  } cim_scale_s;

  cim_scale_s r;
  cim_scale_s n;
  logic [RAW_W-1:0] diff;
  logic [PROD_W-1:0] prod;
  logic [PROD_W-GAIN_SHIFT-1:0] scaled;

  if (PROD_W - GAIN_SHIFT < SAMPLE_W)
  begin : g_bad
    $error("cim_scaler: gain shift leaves too few bits");
  end

  ////////////////////////////////////////////////////////////////////////
  // Offset removal, gain, clamp at full scale
  always_comb
  begin
    n = r;
    diff = (conv.raw > RAW_LO) ? conv.raw - RAW_LO : '0;
    prod = PROD_W'(diff) * PROD_W'(GAIN);
    scaled = prod[PROD_W-1:GAIN_SHIFT];
    n.valid = conv.raw_valid;
    if (conv.raw_valid)
    begin
      n.chan = conv.raw_chan;
      // Low end gives zero, top end saturates at FFF
      n.sample = (scaled > (PROD_W-GAIN_SHIFT)'(SAMPLE_MAX)) ?
        SAMPLE_MAX : scaled[SAMPLE_W-1:0];
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign conv.sample = r.sample;
  assign conv.sample_valid = r.valid;
  assign conv.sample_chan = r.chan;
endmodule : cim_scaler
`default_nettype wire

// ===== core/cim_top.sv
// Four-channel current input sequencer and host input word
`default_nettype none
// Notes on behaviour
// - Two straps set channel count: none 1, first 2, second 3, both 4.
// - Delivered strap setting selects four channels, both straps present.
// - Channels above the selected count are never converted nor reported.
// - Multiplexed mode shows one channel per scan, wrapping after the last.
// - With two channels multiplexed, each refreshes on alternate scans.
// - Pointer mode delivers every enabled channel within one host scan.
// - Conversion runs freely; host values change only with the scan.
// - Word bits 0 to 11 hold the unsigned sample, bit n weighs 2^n.
// - Input range maps linearly onto 0 to FFF.
// - Two code bits give the channel: 00 one, 01 two, 10 three.
// - The device shows the host exactly sixteen input points.
// - Top two word bits are busy and then missing-supply flags.
// - Busy is set on the first host scan after start-up.
// - Later, busy is set only when noise disturbs conversion.
// - Multiplexed, missing supply sets bit 15 and reports zero sample.
// - Pointer mode reports missing supply as the value 8000.
module cim_top
  import cim_pkg::*;
#(
  parameter int CONV_CYCLES_P = cim_pkg::CONV_CYCLES
)
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic strap_one_absent_in,
  input wire logic strap_two_absent_in,
  input wire logic ptr_mode_in,
  input wire logic host_scan_in,
  input wire logic supply_present_in,
  input wire logic conv_done_in,
  input wire logic conv_noise_in,
  input wire logic [cim_pkg::RAW_W-1:0] conv_raw_in,
  output logic conv_start_out,
  output logic [cim_pkg::CH_W-1:0] conv_chan_out,
  output logic scan_ready_out,
  output logic [cim_pkg::WORD_W-1:0] input_word_out,
  output logic channel_code_low_point_out,
  output logic channel_code_high_point_out,
  output logic busy_flag_point_out,
  output logic supply_missing_point_out,
  output logic ptr_valid_out,
  output logic [cim_pkg::CH_W-1:0] ptr_chan_out,
  output logic [cim_pkg::WORD_W-1:0] ptr_word_out
);
  import cim_pkg::*;

  localparam int TMR_W = $clog2(CONV_CYCLES_P + 1);

  if (CONV_CYCLES_P < 2)
  begin : g_bad
    $error("cim_top: conversion interval too short");
  end

  typedef struct packed
  {
    cim_state_e state;
    logic [CH_W-1:0] conv_chan;
    logic [TMR_W-1:0] conv_timer;
    logic conv_start;
    logic conv_wait;
    logic [CH_W-1:0] host_chan;
    logic [CH_W-1:0] ptr_idx;
    logic first_done;
    logic noise_seen;
    logic [WORD_W-1:0] word;
    logic ptr_valid;
    logic [CH_W-1:0] ptr_chan;
    logic [WORD_W-1:0] ptr_word;
  } cim_main_s;

  cim_main_s r;
  cim_main_s n;
  logic [CH_W-1:0] last_chan;
  logic noise_evt;
  logic busy_now;
  logic rd_en_c;
  logic [CH_W-1:0] rd_addr_c;
  logic [CH_W-1:0] chan_sel;
  logic [SAMPLE_W-1:0] rd_data;

  cim_conv_if conv ();

  ////////////////////////////////////////////////////////////////////////
  // Channel count from straps; both absent-flags low gives four
  assign last_chan = ~{strap_two_absent_in, strap_one_absent_in};

  // Completed conversion handed to the scaler
  assign conv.raw = conv_raw_in;
  assign conv.raw_valid = conv_done_in & r.conv_wait;
  assign conv.raw_chan = r.conv_chan;
  assign noise_evt = conv_noise_in & conv_done_in & r.conv_wait;

  ////////////////////////////////////////////////////////////////////////
  // Scaler and sample store
  cim_scaler u_scaler
  (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .conv(conv)
  );

  cim_sample_mem #(
    .WIDTH(SAMPLE_W),
    .DEPTH(CH_CNT)
  ) u_mem
  (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .wr_en_in(conv.sample_valid),
    .wr_addr_in(conv.sample_chan),
    .wr_data_in(conv.sample),
    .rd_en_in(rd_en_c),
    .rd_addr_in(rd_addr_c),
    .rd_data_out(rd_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Free-running conversion pacing and host scan sequencing
  always_comb
  begin
    n = r;
    rd_en_c = 1'b0;
    rd_addr_c = CH_FIRST;
    n.conv_start = 1'b0;
    n.ptr_valid = 1'b0;
    // Noise is remembered until a word reports it; clear wins over set, busy_now takes same-cycle noise
    n.noise_seen = r.noise_seen | noise_evt;
    busy_now = ~r.first_done | r.noise_seen | noise_evt;
    chan_sel = (r.host_chan > last_chan) ? CH_FIRST : r.host_chan;

    // Conversion cycles through enabled channels, blind to the host
    if (r.conv_wait)
    begin
      if (conv_done_in)
      begin
        n.conv_wait = 1'b0;
        n.conv_chan = (r.conv_chan >= last_chan) ? CH_FIRST :
          r.conv_chan + 2'h1;
      end
    end
    else if (r.conv_timer == '0)
    begin
      n.conv_start = 1'b1;
      n.conv_wait = 1'b1;
      n.conv_timer = TMR_W'(CONV_CYCLES_P - 1);
      if (r.conv_chan > last_chan)
      begin
        n.conv_chan = CH_FIRST;
      end
    end
    else
    begin
      n.conv_timer = r.conv_timer - 1'b1;
    end

    unique case (r.state)
      CIM_ST_IDLE:
      begin
        if (host_scan_in)
        begin
          rd_en_c = 1'b1;
          if (ptr_mode_in)
          begin
            rd_addr_c = CH_FIRST;
            n.ptr_idx = CH_FIRST;
            n.state = CIM_ST_PTR;
          end
          else
          begin
            rd_addr_c = chan_sel;
            n.host_chan = chan_sel;
            n.state = CIM_ST_MUX;
          end
        end
      end
      CIM_ST_MUX:
      begin
        // One channel per scan, code bits name it
        n.word[CODE_HIGH_BIT:CODE_LOW_BIT] = r.host_chan;
        n.word[BUSY_BIT] = busy_now;
        n.word[SUPPLY_BIT] = ~supply_present_in;
        n.word[SAMPLE_MSB:SAMPLE_LSB] = supply_present_in ? rd_data :
          SAMPLE_ZERO;
        n.host_chan = (r.host_chan >= last_chan) ? CH_FIRST :
          r.host_chan + 2'h1;
        n.first_done = 1'b1;
        n.noise_seen = 1'b0;
        n.state = CIM_ST_IDLE;
      end
      CIM_ST_PTR:
      begin
        // Burst of every enabled channel in one scan
        n.ptr_valid = 1'b1;
        n.ptr_chan = r.ptr_idx;
        n.ptr_word = supply_present_in ?
          {{(WORD_W-SAMPLE_W){1'b0}}, rd_data} : PTR_SUPPLY_WORD;
        if (r.ptr_idx >= last_chan)
        begin
          n.first_done = 1'b1;
          n.noise_seen = 1'b0;
          n.word[BUSY_BIT] = busy_now;
          n.state = CIM_ST_IDLE;
        end
        else
        begin
          rd_en_c = 1'b1;
          rd_addr_c = r.ptr_idx + 2'h1;
          n.ptr_idx = r.ptr_idx + 2'h1;
        end
      end
      default:
      begin
        n.state = CIM_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      r <= '0;
      r.state <= CIM_ST_IDLE;
    end
    else
    begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sixteen input points, all from the registered word
  assign input_word_out = r.word;
  assign channel_code_low_point_out = r.word[CODE_LOW_BIT];
  assign channel_code_high_point_out = r.word[CODE_HIGH_BIT];
  assign busy_flag_point_out = r.word[BUSY_BIT];
  assign supply_missing_point_out = r.word[SUPPLY_BIT];
  assign conv_start_out = r.conv_start;
  assign conv_chan_out = r.conv_chan;
  assign scan_ready_out = (r.state == CIM_ST_IDLE);
  assign ptr_valid_out = r.ptr_valid;
  assign ptr_chan_out = r.ptr_chan;
  assign ptr_word_out = r.ptr_word;

  ////////////////////////////////////////////////////////////////////////
  // Checks next to the logic
  sequence seq_take_ptr;
    host_scan_in && ptr_mode_in && (r.state == CIM_ST_IDLE);
  endsequence

  sequence seq_take_mux;
    host_scan_in && !ptr_mode_in && (r.state == CIM_ST_IDLE);
  endsequence

  AST_CONV_RANGE: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    conv_start_out |-> conv_chan_out <= last_chan)
    else $error("conversion started on a disabled channel");

  AST_PTR_RANGE: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    ptr_valid_out |-> ptr_chan_out <= last_chan)
    else $error("pointer burst reported a disabled channel");

  AST_PTR_BURST: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    seq_take_ptr |-> ##2 (ptr_valid_out && ptr_chan_out == CH_FIRST))
    else $error("pointer burst did not start two cycles after scan");

  AST_MUX_WRAP: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (r.state == CIM_ST_MUX && r.host_chan == last_chan)
    |=> r.host_chan == CH_FIRST)
    else $error("multiplexed channel did not wrap to the first");

  AST_MUX_CODE: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    seq_take_mux ##1 1'b1 |=>
    {channel_code_high_point_out, channel_code_low_point_out}
      == $past(r.host_chan))
    else $error("channel code does not match presented channel");

  AST_WORD_ON_SCAN: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    $changed(input_word_out) |-> $past(r.state, 1) != CIM_ST_IDLE)
    else $error("input word changed without a host scan");

  AST_FIRST_BUSY: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (r.state == CIM_ST_MUX && !r.first_done) |=> busy_flag_point_out)
    else $error("busy not shown on first scan");

  AST_QUIET_CLEAR: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (r.state == CIM_ST_MUX && r.first_done && !r.noise_seen && !noise_evt)
    |=> !busy_flag_point_out)
    else $error("busy shown without noise after first scan");

  AST_SUPPLY_MUX: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (r.state == CIM_ST_MUX && !supply_present_in) |=>
    (supply_missing_point_out && input_word_out[SAMPLE_MSB:SAMPLE_LSB] == 0))
    else $error("missing supply not flagged with zero sample");

  AST_SUPPLY_PTR: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (r.state == CIM_ST_PTR && !supply_present_in) |=>
    (ptr_valid_out && ptr_word_out == PTR_SUPPLY_WORD))
    else $error("pointer word not 8000 on missing supply");

  // Pointer burst walks channels in order and stops after the last
  AST_PTR_STEP: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (ptr_valid_out && ptr_chan_out < last_chan) |=>
    (ptr_valid_out && ptr_chan_out == $past(ptr_chan_out) + 2'h1))
    else $error("pointer burst skipped a channel or stopped early");

  AST_PTR_END: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (ptr_valid_out && ptr_chan_out == last_chan) |=> !ptr_valid_out)
    else $error("pointer burst ran past the last enabled channel");

  // Sample words in pointer mode carry nothing above the sample
  AST_PTR_PAD: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    (r.state == CIM_ST_PTR && supply_present_in) |=>
    (ptr_word_out[WORD_W-1:SAMPLE_W] == '0))
    else $error("pointer sample word has upper bits set");

  // A delivered word never names a channel beyond the strap count
  AST_CODE_RANGE: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    $changed(input_word_out) |->
    ({channel_code_high_point_out, channel_code_low_point_out} <= last_chan))
    else $error("channel code names a disabled channel");

  AST_START_PULSE: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    conv_start_out |=> !conv_start_out)
    else $error("conversion start held longer than one cycle");
endmodule : cim_top
`default_nettype wire

// ===== verification/cim_conv_model.sv
// Behavioural converter that answers the block's conversion starts
`default_nettype none
module cim_conv_model
  import cim_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [CH_W-1:0] chan_in,
  input wire logic slow_in,
  input wire logic noisy_in,
  input wire logic [4*RAW_W-1:0] raw_tab_in,
  output logic done_out,
  output logic noise_out,
  output logic [RAW_W-1:0] raw_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_r;
  logic [3:0] wait_r;
  logic [CH_W-1:0] chan_r;
  ////////////////////////////////////////////////////////////////////////
  // Prompt or slow answer; code and noise are garbage outside done
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      busy_r <= 1'b0;
      wait_r <= 4'h0;
      chan_r <= '0;
      done_out <= 1'b0;
      noise_out <= 1'b0;
      raw_out <= '0;
    end
    else
    begin
      done_out <= 1'b0;
      noise_out <= ~noise_out;
      raw_out <= ~raw_out;
      if (start_in)
      begin
        busy_r <= 1'b1;
        chan_r <= chan_in;
        wait_r <= slow_in ? 4'h7 : 4'h0;
      end
      else if (busy_r && wait_r != 4'h0)
        wait_r <= wait_r - 4'h1;
      else if (busy_r)
      begin
        busy_r <= 1'b0;
        done_out <= 1'b1;
        noise_out <= noisy_in;
        raw_out <= raw_tab_in[chan_r*RAW_W +: RAW_W];
      end
    end
  end
endmodule : cim_conv_model
`default_nettype wire

// ===== verification/four_channel_current_input_mux_bench.sv
// Self-checking bench of the four-channel current input block
`default_nettype none
module four_channel_current_input_mux_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cim_pkg::*;
  localparam int CONV_P = 4;
  localparam int LIMIT = 20000;
  localparam logic [4*RAW_W-1:0] RAW_INIT =
    {RAW_LO, 14'h3FFF, RAW_LO, 14'h3FFF};
  logic core_clk = 1'b0;
  logic rst = 1'b0;
  logic one_absent = 1'b0;
  logic two_absent = 1'b0;
  logic ptr_mode = 1'b0;
  logic host_scan = 1'b0;
  logic supply = 1'b1;
  logic slow = 1'b0;
  logic noisy = 1'b0;
  logic [4*RAW_W-1:0] raw_tab = RAW_INIT;
  logic done, noise, start, ready, ptr_valid;
  logic [RAW_W-1:0] raw;
  logic [CH_W-1:0] conv_chan, ptr_chan, cur, last;
  logic [WORD_W-1:0] word, ptr_word;
  wire [3:0] pts;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  int starts = 0;
  assign last = ~{two_absent, one_absent};
  ////////////////////////////////////////////////////////////////////////
  // Design and converter model
  cim_top #(.CONV_CYCLES_P(CONV_P)) uut (
    .core_clk_in(core_clk), .rst_in(rst),
    .strap_one_absent_in(one_absent), .strap_two_absent_in(two_absent),
    .ptr_mode_in(ptr_mode), .host_scan_in(host_scan),
    .supply_present_in(supply), .conv_done_in(done),
    .conv_noise_in(noise), .conv_raw_in(raw), .conv_start_out(start),
    .conv_chan_out(conv_chan), .scan_ready_out(ready),
    .input_word_out(word), .channel_code_low_point_out(pts[0]),
    .channel_code_high_point_out(pts[1]), .busy_flag_point_out(pts[2]),
    .supply_missing_point_out(pts[3]), .ptr_valid_out(ptr_valid),
    .ptr_chan_out(ptr_chan), .ptr_word_out(ptr_word)
  );
  cim_conv_model partner (
    .core_clk_in(core_clk), .rst_in(rst), .start_in(start),
    .chan_in(conv_chan), .slow_in(slow), .noisy_in(noisy),
    .raw_tab_in(raw_tab), .done_out(done), .noise_out(noise),
    .raw_out(raw)
  );
  ////////////////////////////////////////////////////////////////////////
  // Clock
  always #5 core_clk = ~core_clk;
  // Cycle ceiling and watch on converted channels
  always @(negedge core_clk)
  begin
    cycles++;
    if (start === 1'b1)
      starts++;
    if (start === 1'b1)
      chk("conv_chan_over", 16'h0, {15'h0, conv_chan > last});
    if (cycles >= LIMIT)
    begin
      errors++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input string what, input logic [15:0] exp, got);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic do_reset(input logic two, one);
    rst = 1'b1;
    two_absent = two;
    one_absent = one;
    repeat (16) @(posedge core_clk);
    #1 rst = 1'b0;
    cur = CH_FIRST;
  endtask : do_reset
  task automatic settle();
    repeat (120) @(posedge core_clk);
    #1;
  endtask : settle
  function automatic logic [11:0] exp_sample(input logic [1:0] ch);
    return (raw_tab[ch*RAW_W +: RAW_W] == RAW_LO) ? SAMPLE_ZERO : SAMPLE_MAX;
  endfunction : exp_sample
  // One host scan; returns where the answer has settled
  task automatic scan(input logic ptr);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 50)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    chk("scan_ready_idle", 16'h1, {15'h0, ready});
    ptr_mode = ptr;
    host_scan = 1'b1;
    @(posedge core_clk);
    #1 host_scan = 1'b0;
    chk("scan_ready_taken", 16'h0, {15'h0, ready});
    @(posedge core_clk);
    #1;
  endtask : scan
  task automatic mux_scan(input logic busy, miss);
    logic [15:0] e;
    scan(1'b0);
    e = {miss, busy, cur, miss ? SAMPLE_ZERO : exp_sample(cur)};
    chk("input_word", e, word);
    chk("points", {12'h0, e[15:12]}, {12'h0, pts});
    cur = (cur == last) ? CH_FIRST : cur + 2'h1;
  endtask : mux_scan
  task automatic ptr_burst(input logic miss);
    int k;
    logic [1:0] ch;
    ch = CH_FIRST;
    scan(1'b1);
    for (k = 0; k <= int'(last); k++)
    begin
      chk("ptr_valid", 16'h1, {15'h0, ptr_valid});
      chk("ptr_chan", {14'h0, ch}, {14'h0, ptr_chan});
      chk("ptr_word", miss ? PTR_SUPPLY_WORD : {4'h0, exp_sample(ch)},
          ptr_word);
      ch++;
      @(posedge core_clk);
      #1;
    end
    chk("ptr_end", 16'h0, {15'h0, ptr_valid});
  endtask : ptr_burst
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_default();
    do_reset(1'b0, 1'b0);
    settle();
    mux_scan(1'b1, 1'b0);
    repeat (4) mux_scan(1'b0, 1'b0);
  endtask : t_default
  task automatic t_hold();
    logic [15:0] w;
    int s;
    w = word;
    s = starts;
    raw_tab = {4{RAW_LO}};
    settle();
    chk("word_held", w, word);
    chk("free_running", 16'h1, {15'h0, starts > s + 4});
    repeat (4) mux_scan(1'b0, 1'b0);
    raw_tab = RAW_INIT;
    settle();
  endtask : t_hold
  task automatic t_noise();
    noisy = 1'b1;
    settle();
    noisy = 1'b0;
    settle();
    mux_scan(1'b1, 1'b0);
    mux_scan(1'b0, 1'b0);
  endtask : t_noise
  task automatic t_supply();
    supply = 1'b0;
    settle();
    mux_scan(1'b0, 1'b1);
    ptr_burst(1'b1);
    supply = 1'b1;
    slow = 1'b1;
    settle();
    ptr_burst(1'b0);
    slow = 1'b0;
  endtask : t_supply
  task automatic t_straps();
    int s;
    for (s = 3; s >= 1; s--)
    begin
      do_reset(s[1], s[0]);
      settle();
      mux_scan(1'b1, 1'b0);
      repeat (3) mux_scan(1'b0, 1'b0);
      ptr_burst(1'b0);
    end
  endtask : t_straps
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    t_default();
    t_hold();
    t_noise();
    t_supply();
    t_straps();
    finish_test();
  end
endmodule : four_channel_current_input_mux_bench
`default_nettype wire
